/* File: verilog/mps_consts.svh */
// Constants for the multiphase PWM start-up sequencer
`ifndef MPS_CONSTS_SVH
`define MPS_CONSTS_SVH

`define MPS_CLK_MHZ 40
`define MPS_DAC_W 10
`define MPS_LSB_UV 2500
`define MPS_BOOT_MV 1100
`define MPS_VID_TOP_MV 1500
`define MPS_VID_STEP_UV 12500
`define MPS_SS_RATE_UV_US 2500
`define MPS_VID_RATE_UV_US 5000
`define MPS_BOOT_CYCLES 13
`define MPS_POR_DELAY_US 120
`define MPS_PG_DELAY_MS 7
`define MPS_SETPOINT_RESET 10'h000
`define MPS_SEL_ONE 2'h0
`define MPS_SEL_TWO 2'h1

`define MPS_US_CYCLES (1 * `MPS_CLK_MHZ)
`define MPS_POR_DELAY_CYCLES (`MPS_POR_DELAY_US * `MPS_CLK_MHZ)
`define MPS_PG_DELAY_CYCLES (`MPS_PG_DELAY_MS * 1000 * `MPS_CLK_MHZ)
`define MPS_BOOT_CODE (`MPS_BOOT_MV * 1000 / `MPS_LSB_UV)
`define MPS_TOP_CODE (`MPS_VID_TOP_MV * 1000 / `MPS_LSB_UV)
`define MPS_VID_STEP_CODE (`MPS_VID_STEP_UV / `MPS_LSB_UV)
`define MPS_SS_STEP_CODE (`MPS_SS_RATE_UV_US / `MPS_LSB_UV)
`define MPS_VID_SLEW_CODE (`MPS_VID_RATE_UV_US / `MPS_LSB_UV)

`endif

/* File: verilog/mps_pkg.sv */
// Types shared by the sequencer and its phase slaves
`include "mps_consts.svh"

package mps_pkg;

	typedef logic [`MPS_DAC_W-1:0] mps_dac_t;

	typedef enum logic [1:0] {MPS_ONE, MPS_TWO, MPS_THREE} mps_mode_t;

	typedef enum logic [2:0] {MPS_IDLE, MPS_PORWAIT, MPS_SOFT, MPS_QUAL, MPS_REG} mps_state_t;

	typedef struct packed {
		logic rampAtComp;
		logic [2:0] slaveAtWindow;
		logic [2:0] zeroCross;
		logic nearBoot;
		logic porOk;
		logic regulatorOnRequest;
		logic diodeEmulationMode;
		logic [1:0] phaseCountSel;
		logic [6:0] voltageIdentifierCode;
	} mps_pins_t;

	typedef struct packed {
		logic [2:0] pwm;
		logic [2:0] lowSideGateDrive;
	} mps_drive_t;

endpackage : mps_pkg

/* File: verilog/mps_phase_slave.sv */
// One phase slave: PWM latch and low-side gate with diode emulation
`timescale 1ns/100ps

module mps_phase_slave
	import mps_pkg::*;
(
	input wire logic clock,
	input wire logic resetn,
	input wire logic enable,
	input wire logic phaseClock,
	input wire logic atWindow,
	input wire logic zeroCross,
	input wire logic diodeEmulationMode,
	output logic pwm_q,
	output logic lowGate_q
);

	logic pwm_d;
	logic cut_d;
	logic cut_q;

	// Clock pulse wins over a window trip in the same cycle
	always_comb begin
		if (!enable) begin
			pwm_d = 1'b0;
		end else if (phaseClock) begin
			pwm_d = 1'b1;
		end else if (atWindow) begin
			pwm_d = 1'b0;
		end else begin
			pwm_d = pwm_q;
		end
	end

	always_comb begin
		if (!enable || !diodeEmulationMode || phaseClock) begin
			cut_d = 1'b0;
		end else if (zeroCross && !pwm_d) begin
			cut_d = 1'b1;
		end else begin
			cut_d = cut_q;
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			pwm_q <= 1'b0;
			cut_q <= 1'b0;
			lowGate_q <= 1'b0;
		end else begin
			pwm_q <= pwm_d;
			cut_q <= cut_d;
			// Never overlap the high side; stay off once current has reached zero
			lowGate_q <= enable && !pwm_d && !cut_d;
		end
	end

	default clocking @(posedge clock); endclocking
	default disable iff (!resetn);

	pwmOnClock_a: assert property (enable && phaseClock |=> pwm_q)
		else $error("PWM not set by phase clock");

	pwmOffWindow_a: assert property (enable && pwm_q && atWindow && !phaseClock
		|=> !pwm_q ##1 (!pwm_q || $past(phaseClock)))
		else $error("PWM not cleared at window level");

	deCutGate_a: assert property (enable && diodeEmulationMode && zeroCross && !phaseClock && !pwm_q
		|=> !lowGate_q)
		else $error("Low-side gate still on after zero crossing");

endmodule : mps_phase_slave

/* File: verilog/mps_sequencer_top.sv */
// Master clock, phase sequencer and start-up sequencer of the multiphase buck
`timescale 1ns/100ps

module mps_sequencer_top
	import mps_pkg::*;
#(
	parameter logic [12:0] PorDelayCycles = 13'(`MPS_POR_DELAY_CYCLES),
	parameter logic [18:0] PgDelayCycles = 19'(`MPS_PG_DELAY_CYCLES)
)
(
	input wire logic clock,
	input wire logic resetn,
	input mps_pins_t pins,
	output logic masterClockPulse,
	output logic rampReset,
	output logic [2:0] phaseClock,
	output mps_drive_t drive,
	output mps_dac_t setpoint,
	output logic clockEnableN,
	output logic powerGoodOut
);

	// ********************************************
	// Input synchronisers
	// ********************************************

	mps_pins_t syncA_q;
	mps_pins_t syncB_q;

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			syncA_q <= '0;
			syncB_q <= '0;
		end else begin
			syncA_q <= pins;
			syncB_q <= syncA_q;
		end
	end

	// ********************************************
	// Helpers
	// ********************************************

	function automatic mps_mode_t decodeMode(input logic [1:0] sel);
		if (sel == `MPS_SEL_ONE) begin
			decodeMode = MPS_ONE;
		end else if (sel == `MPS_SEL_TWO) begin
			decodeMode = MPS_TWO;
		end else begin
			decodeMode = MPS_THREE;
		end
	endfunction : decodeMode

	function automatic logic [1:0] nextIdx(input logic [1:0] idx, input mps_mode_t mode);
		logic [1:0] last;
		last = (mode == MPS_ONE) ? 2'h0 : ((mode == MPS_TWO) ? 2'h1 : 2'h2);
		nextIdx = (idx >= last) ? 2'h0 : 2'(idx + 2'h1);
	endfunction : nextIdx

	// Moves toward a target by at most one step, never overshooting
	function automatic mps_dac_t stepToward(input mps_dac_t cur, input mps_dac_t tgt,
		input mps_dac_t step);
		if (cur + step <= tgt && cur < tgt) begin
			stepToward = mps_dac_t'(cur + step);
		end else if (cur < tgt) begin
			stepToward = tgt;
		end else if (cur >= tgt + step && cur > tgt) begin
			stepToward = mps_dac_t'(cur - step);
		end else begin
			stepToward = tgt;
		end
	endfunction : stepToward

	function automatic mps_dac_t vidTarget(input logic [6:0] code);
		vidTarget = mps_dac_t'(`MPS_TOP_CODE - code * `MPS_VID_STEP_CODE);
	endfunction : vidTarget

	// ********************************************
	// Start-up state machine
	// ********************************************

	mps_state_t state_q;
	mps_state_t state_d;
	logic [12:0] porAge_q;
	logic [5:0] usCnt_q;
	logic usTick;
	logic [3:0] qualCnt_q;
	logic [18:0] pgCnt_q;
	mps_dac_t setpoint_q;
	logic clkEnN_q;
	logic powerGood_q;
	logic startOk;
	logic running;
	logic fire;

	assign startOk = syncB_q.porOk && syncB_q.regulatorOnRequest;
	assign running = (state_q == MPS_SOFT) || (state_q == MPS_QUAL) || (state_q == MPS_REG);
	assign usTick = (usCnt_q == 6'(`MPS_US_CYCLES - 1));

	always_comb begin
		state_d = state_q;
		case (state_q)
			MPS_IDLE: begin
				if (startOk) begin
					state_d = MPS_PORWAIT;
				end
			end
			MPS_PORWAIT: begin
				if (porAge_q == PorDelayCycles) begin
					state_d = MPS_SOFT;
				end
			end
			MPS_SOFT: begin
				if (setpoint_q == mps_dac_t'(`MPS_BOOT_CODE)) begin
					state_d = MPS_QUAL;
				end
			end
			MPS_QUAL: begin
				if (qualCnt_q == 4'(`MPS_BOOT_CYCLES)) begin
					state_d = MPS_REG;
				end
			end
			default: begin
				state_d = state_q;
			end
		endcase
		if (!startOk) begin
			state_d = MPS_IDLE;
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			state_q <= MPS_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	// Age since the supply became good, saturating at the start delay
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			porAge_q <= '0;
		end else if (!syncB_q.porOk) begin
			porAge_q <= '0;
		end else if (porAge_q != PorDelayCycles) begin
			porAge_q <= 13'(porAge_q + 13'h1);
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			usCnt_q <= '0;
		end else if (!running || usTick) begin
			usCnt_q <= '0;
		end else begin
			usCnt_q <= 6'(usCnt_q + 6'h1);
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			setpoint_q <= `MPS_SETPOINT_RESET;
		end else if (!running) begin
			setpoint_q <= `MPS_SETPOINT_RESET;
		end else if (usTick && state_q == MPS_SOFT) begin
			setpoint_q <= stepToward(setpoint_q, mps_dac_t'(`MPS_BOOT_CODE),
				mps_dac_t'(`MPS_SS_STEP_CODE));
		end else if (usTick && state_q == MPS_REG) begin
			setpoint_q <= stepToward(setpoint_q, vidTarget(syncB_q.voltageIdentifierCode),
				mps_dac_t'(`MPS_VID_SLEW_CODE));
		end
	end

	// A cycle outside the band restarts the count; only consecutive cycles qualify
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			qualCnt_q <= '0;
		end else if (state_q != MPS_QUAL) begin
			qualCnt_q <= '0;
		end else if (fire) begin
			qualCnt_q <= syncB_q.nearBoot ? 4'(qualCnt_q + 4'h1) : 4'h0;
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			clkEnN_q <= 1'b1;
		end else begin
			clkEnN_q <= (state_d != MPS_REG);
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			pgCnt_q <= '0;
			powerGood_q <= 1'b0;
		end else begin
			if (state_d == MPS_IDLE) begin
				pgCnt_q <= '0;
			end else if (pgCnt_q != PgDelayCycles) begin
				pgCnt_q <= 19'(pgCnt_q + 19'h1);
			end
			powerGood_q <= (state_d == MPS_REG) && (pgCnt_q == PgDelayCycles);
		end
	end

	// ********************************************
	// Master clock and phase sequencer
	// ********************************************

	logic rampLast_q;
	logic masterPulse_q;
	logic rampReset_q;
	logic [2:0] phaseClock_q;
	logic [1:0] seqIdx_q;
	logic [1:0] idxNow;
	mps_mode_t modeNow;
	mps_mode_t modeLast_q;
	mps_mode_t issueMode_q;
	logic modeRestart;

	assign modeNow = decodeMode(syncB_q.phaseCountSel);
	assign fire = syncB_q.rampAtComp && !rampLast_q && running;
	assign modeRestart = (modeNow != modeLast_q) || !running;
	assign idxNow = modeRestart ? 2'h0 : seqIdx_q;

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			rampLast_q <= 1'b0;
			modeLast_q <= MPS_ONE;
			seqIdx_q <= '0;
		end else begin
			rampLast_q <= syncB_q.rampAtComp;
			modeLast_q <= modeNow;
			seqIdx_q <= fire ? nextIdx(idxNow, modeNow) : idxNow;
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			masterPulse_q <= 1'b0;
			rampReset_q <= 1'b0;
			phaseClock_q <= '0;
			issueMode_q <= MPS_ONE;
		end else begin
			masterPulse_q <= fire;
			rampReset_q <= fire;
			phaseClock_q <= fire ? 3'(3'h1 << idxNow) : 3'h0;
			if (fire) begin
				issueMode_q <= modeNow;
			end
		end
	end

	// ********************************************
	// Phase slaves
	// ********************************************

	logic [2:0] pwmQ;
	logic [2:0] lowGateQ;

	for (genvar i = 0; i < 3; i++) begin : gPhase
		mps_phase_slave uSlave (
			.clock(clock),
			.resetn(resetn),
			.enable(running),
			.phaseClock(phaseClock_q[i]),
			.atWindow(syncB_q.slaveAtWindow[i]),
			.zeroCross(syncB_q.zeroCross[i]),
			.diodeEmulationMode(syncB_q.diodeEmulationMode),
			.pwm_q(pwmQ[i]),
			.lowGate_q(lowGateQ[i])
		);
	end

	assign masterClockPulse = masterPulse_q;
	assign rampReset = rampReset_q;
	assign phaseClock = phaseClock_q;
	assign drive = '{pwm: pwmQ, lowSideGateDrive: lowGateQ};
	assign setpoint = setpoint_q;
	assign clockEnableN = clkEnN_q;
	assign powerGoodOut = powerGood_q;

	// ********************************************
	// Checks
	// ********************************************

	logic [2:0] lastHit_q;
	logic restartSeen_q;

	// Remembers the last phase hit; cleared when the rotation restarts
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			lastHit_q <= '0;
			restartSeen_q <= 1'b1;
		end else begin
			restartSeen_q <= modeRestart;
			if (phaseClock_q != 3'h0) begin
				lastHit_q <= phaseClock_q;
			end else if (restartSeen_q) begin
				lastHit_q <= '0;
			end
		end
	end

	default clocking @(posedge clock); endclocking
	default disable iff (!resetn);

	sequence rampRise_s;
		syncB_q.rampAtComp && !rampLast_q && running;
	endsequence

	sequence oneShot_s;
		masterPulse_q && rampReset_q ##1 !masterPulse_q;
	endsequence

	masterOneShot_a: assert property (rampRise_s |=> oneShot_s)
		else $error("Master pulse not a single one-shot");

	phaseRotation_a: assert property (phaseClock_q != 3'h0 && lastHit_q != 3'h0 && !restartSeen_q
		|-> phaseClock_q == ((issueMode_q == MPS_THREE) ? {lastHit_q[1:0], lastHit_q[2]}
		: ((issueMode_q == MPS_TWO) ? {1'b0, lastHit_q[0], lastHit_q[1]} : 3'h1)))
		else $error("Phase rotation out of order");

	twoPhaseMask_a: assert property (phaseClock_q != 3'h0 && issueMode_q == MPS_TWO
		|-> !phaseClock_q[2])
		else $error("Phase three clocked in two-phase mode");

	onePhaseOnly_a: assert property (masterPulse_q && issueMode_q == MPS_ONE
		|-> phaseClock_q == 3'h1)
		else $error("Single-phase pulse not on phase one");

	restartPhaseOne_a: assert property ((phaseClock_q != 3'h0) && (restartSeen_q || lastHit_q == 3'h0)
		|-> phaseClock_q == 3'h1)
		else $error("Rotation did not restart at phase one");

	startNeedsSupply_a: assert property (state_q != MPS_IDLE |-> $past(startOk))
		else $error("Sequence running without supply and request");

	softStartRate_a: assert property (state_q == MPS_SOFT && $changed(setpoint_q)
		|-> $past(usTick) && setpoint_q == mps_dac_t'($past(setpoint_q) + 1'b1))
		else $error("Soft-start ramp rate wrong");

	bootQualified_a: assert property ($fell(clkEnN_q) |-> $past(qualCnt_q) == 4'(`MPS_BOOT_CYCLES))
		else $error("Boot declared without 13 qualifying cycles");

	vidSlewRate_a: assert property (state_q == MPS_REG && $past(state_q) == MPS_REG && $changed(setpoint_q)
		|-> $past(usTick) && (setpoint_q - $past(setpoint_q) <= mps_dac_t'(`MPS_VID_SLEW_CODE)
		|| $past(setpoint_q) - setpoint_q <= mps_dac_t'(`MPS_VID_SLEW_CODE)))
		else $error("Identifier slew rate wrong");

	powerGoodDelay_a: assert property ($rose(powerGood_q) |-> $past(pgCnt_q) == PgDelayCycles)
		else $error("Power-good raised before its delay");

	porStartDelay_a: assert property (state_q == MPS_SOFT && $past(state_q) == MPS_PORWAIT
		|-> $past(porAge_q) == PorDelayCycles)
		else $error("Soft start began before supply delay");

endmodule : mps_sequencer_top

/* File: verif/mps_stage_model.sv */
// Behavioural power stage, ramps and comparators facing the sequencer
`timescale 1ns/100ps

module mps_stage_model
	import mps_pkg::*;
(
	input wire logic clock,
	input wire logic rampEn,
	input wire logic [2:0] pwm,
	input mps_dac_t setpoint,
	output logic rampAtComp,
	output logic [2:0] slaveAtWindow,
	output logic [2:0] zeroCross,
	output logic nearBoot
);
	int rampCnt = 0;
	int onCnt [3] = '{0, 0, 0};
	int offCnt [3] = '{0, 0, 0};

	initial begin
		rampAtComp = 1'b0;
		slaveAtWindow = 3'h0;
		zeroCross = 3'h0;
		nearBoot = 1'b0;
	end

	// Master ramp meets compensation every 32 cycles, held 3 cycles so it is never missed
	always @(posedge clock) begin
		rampCnt <= (rampCnt == 31) ? 0 : rampCnt + 1;
		rampAtComp <= rampEn && (rampCnt < 3);
		nearBoot <= (setpoint >= 10'h18C) && (setpoint <= 10'h1E4);
		for (int i = 0; i < 3; i++) begin
			onCnt[i] <= pwm[i] ? onCnt[i] + 1 : 0;
			offCnt[i] <= pwm[i] ? 0 : offCnt[i] + 1;
			slaveAtWindow[i] <= pwm[i] && (onCnt[i] >= 8);
			zeroCross[i] <= !pwm[i] && (offCnt[i] >= 6);
		end
	end
endmodule : mps_stage_model

/* File: verif/mps_sequencer_top_test.sv */
// Self-checking bench for the multiphase sequencer top
`timescale 1ns/100ps

module mps_sequencer_top_test
	import mps_pkg::*;
;
	logic clock = 1'b0;
	logic resetn = 1'b0;
	logic porOk = 1'b0;
	logic request = 1'b0;
	logic deMode = 1'b0;
	logic rampEn = 1'b0;
	logic [1:0] phaseSel = 2'h0;
	logic [6:0] vidCode = 7'h14;
	logic ramp, nearB, masterClockPulse, rampReset, clockEnableN, powerGoodOut;
	logic [2:0] atWin, zc, phaseClock, pc;
	mps_pins_t pins;
	mps_drive_t drive;
	mps_dac_t setpoint;
	int miscompares = 0;
	int samplesChecked = 0;
	int cycles = 0;
	int n = 0;

	always #12.5 clock = ~clock;

	assign pins = {ramp, atWin, zc, nearB, porOk, request, deMode, phaseSel, vidCode};

	mps_sequencer_top #(.PorDelayCycles(13'h0014), .PgDelayCycles(19'h07D0)) dut (
		.clock(clock),
		.resetn(resetn),
		.pins(pins),
		.masterClockPulse(masterClockPulse),
		.rampReset(rampReset),
		.phaseClock(phaseClock),
		.drive(drive),
		.setpoint(setpoint),
		.clockEnableN(clockEnableN),
		.powerGoodOut(powerGoodOut)
	);

	mps_stage_model stage (
		.clock(clock),
		.rampEn(rampEn),
		.pwm(drive.pwm),
		.setpoint(setpoint),
		.rampAtComp(ramp),
		.slaveAtWindow(atWin),
		.zeroCross(zc),
		.nearBoot(nearB)
	);

	// ********************
	// Checking and closing
	// ********************
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		samplesChecked++;
		if (seen !== exp) begin
			miscompares++;
			$display("[ERR] %s expected %0h seen %0h", what, exp, seen);
		end
	endtask : check

	task automatic stop_test();
		$display("checks %0d mismatches %0d", samplesChecked, miscompares);
		if (miscompares == 0 && samplesChecked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : stop_test

	// Whole run is about 22k cycles
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 40000) begin
			miscompares++;
			stop_test();
		end
	end

	// ********************
	// Helpers
	// ********************
	task automatic wait_dac(input mps_dac_t target);
		n = 0;
		do begin
			@(negedge clock);
			n++;
		end while (setpoint !== target && n < 20000);
		check("setpointTarget", setpoint, target);
	endtask : wait_dac

	task automatic next_pulse();
		n = 0;
		do begin
			@(negedge clock);
			n++;
		end while (masterClockPulse !== 1'b1 && n < 100);
		check("masterClockPulse", masterClockPulse, 1);
		check("rampReset", rampReset, 1);
		pc = phaseClock;
		@(negedge clock);
		check("pulseWidth", masterClockPulse, 0);
		check("pwmSet", drive.pwm & pc, pc);
	endtask : next_pulse

	// ********************
	// Scenarios
	// ********************
	task automatic check_reset();
		@(negedge clock);
		check("resetDac", setpoint, 0);
		check("resetClkEnN", clockEnableN, 1);
		check("resetPgood", powerGoodOut, 0);
		check("resetDrive", drive, 0);
	endtask : check_reset

	task automatic drop_request();
		@(posedge clock) request <= 1'b0;
		repeat (5) @(negedge clock);
		check("idleDac", setpoint, 0);
		check("idleClkEnN", clockEnableN, 1);
		check("idlePwm", drive.pwm, 0);
		check("idlePgood", powerGoodOut, 0);
	endtask : drop_request

	task automatic tied_start();
		@(posedge clock) begin
			porOk <= 1'b1;
			request <= 1'b1;
			rampEn <= 1'b1;
		end
		wait_dac(10'h001);
		check("porDelay", n >= 58 && n <= 68, 1);
		drop_request();
	endtask : tied_start

	task automatic idle_ignore();
		int pulses;
		pulses = 0;
		repeat (100) begin
			@(negedge clock);
			if (masterClockPulse !== 1'b0)
				pulses++;
		end
		check("idlePulses", pulses, 0);
	endtask : idle_ignore

	task automatic soft_start();
		@(posedge clock) request <= 1'b1;
		wait_dac(10'h001);
		wait_dac(10'h1B8);
		check("softRampCycles", n, 17560);
		check("softClkEnN", clockEnableN, 1);
		check("softPgood", powerGoodOut, 0);
	endtask : soft_start

	task automatic qualify();
		int pulses;
		pulses = 0;
		n = 0;
		while (clockEnableN !== 1'b0 && n < 1000) begin
			@(negedge clock);
			n++;
			if (masterClockPulse === 1'b1)
				pulses++;
		end
		check("bootEvents", pulses >= 13 && pulses <= 14, 1);
		check("clkEnNLow", clockEnableN, 0);
		repeat (2) @(negedge clock);
		check("pgoodHigh", powerGoodOut, 1);
	endtask : qualify

	task automatic vid_slew();
		wait_dac(10'h1F4);
		check("slewUp", n >= 1150 && n <= 1250, 1);
		@(posedge clock) vidCode <= 7'h00;
		wait_dac(10'h258);
		check("slewTop", n >= 1950 && n <= 2050, 1);
	endtask : vid_slew

	task automatic rotation(input logic [1:0] sel, input logic [11:0] order);
		next_pulse();
		@(posedge clock) phaseSel <= sel;
		for (int k = 0; k < 4; k++) begin
			next_pulse();
			check("phaseOrder", pc, order[11 - 3 * k -: 3]);
			n = 0;
			while ((drive.pwm & pc) !== 3'h0 && n < 30) begin
				@(negedge clock);
				n++;
			end
			check("pwmWidth", n >= 8 && n <= 14, 1);
		end
	endtask : rotation

	task automatic diode_emulation();
		for (int m = 0; m < 2; m++) begin
			@(posedge clock) deMode <= m[0];
			next_pulse();
			next_pulse();
			while (drive.pwm[0] !== 1'b0)
				@(negedge clock);
			repeat (14) @(negedge clock);
			check("lowGate", drive.lowSideGateDrive[0], !m[0]);
		end
	endtask : diode_emulation

	// ********************
	// Main sequence
	// ********************
	initial begin
		repeat (8) @(posedge clock);
		resetn <= 1'b1;
		check_reset();
		tied_start();
		idle_ignore();
		soft_start();
		qualify();
		vid_slew();
		rotation(2'h2, 12'b001_010_100_001);
		rotation(2'h1, 12'b001_010_001_010);
		rotation(2'h3, 12'b001_010_100_001);
		rotation(2'h0, 12'b001_001_001_001);
		diode_emulation();
		drop_request();
		stop_test();
	end
endmodule : mps_sequencer_top_test
